// >>> hw/twsb_pkg.sv
// Purpose: shared constants and types of the two-wire slave bit link
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: serial lines travel as a packed pair of clock and data
package twsb_pkg;

  // serial line pair, clock in the upper bit
  typedef struct packed {
    logic scl;
    logic sda;
  } twsb_line_type;

  // byte framing
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 7;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam int MSB_POS = 7;
  localparam int NEXT_MSB_POS = 6;
  localparam int RW_POS = 0;

  // reset values
  localparam twsb_line_type LINE_IDLE = 2'h3;
  localparam twsb_line_type LINE_ZERO = 2'h0;
  localparam logic PULLUP_RST = 1'h0;
  localparam logic [BYTE_BITS-1:0] BYTE_RST = 8'h00;

  // timing of the master clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_MAX_KHZ = 100;
  localparam int SCL_MIN_PERIOD_CYC = 1000000 / (SCL_MAX_KHZ * CLK_PERIOD_NS);

  // link states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } twsb_state_type;

endpackage

// >>> hw/twsb_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous pins
// Assumes: inputs come from outside the clock domain
// Notes: only the second stage leaves the module
module twsb_sync
  import twsb_pkg::*;
#(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] stab_d;

  always_comb
  begin
    meta_d = d;
    stab_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      q <= stab_d;
    end
  end

endmodule

// >>> hw/twsb_shreg.sv
// Purpose: byte shift register, msb first in both directions
// Assumes: load wins over shift
// Notes: q is registered
module twsb_shreg
  import twsb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [BYTE_BITS-1:0] load_val,
  input wire logic shift,
  input wire logic bit_in,
  output logic [BYTE_BITS-1:0] q
);

  logic [BYTE_BITS-1:0] q_d;

  always_comb
  begin
    q_d = q;
    if (load)
    begin
      q_d = load_val;
    end
    else if (shift)
    begin
      q_d = {q[BYTE_BITS-2:0], bit_in};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= BYTE_RST;
    end
    else
    begin
      q <= q_d;
    end
  end

endmodule

// >>> hw/twsb_link.sv
// Purpose: slave side of a two-wire open-drain serial link, bit and byte level
// Assumes: master clock at most 100 kHz, 100 MHz internal clock
// Notes: user side gets received bytes and supplies bytes to return
module twsb_link
  import twsb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire twsb_line_type line_i,
  output twsb_line_type line_o,
  output twsb_line_type line_oe,
  input wire logic pullup_cfg,
  output logic pullup_en_q,
  input wire logic [ADDR_BITS-1:0] own_addr,
  output logic [BYTE_BITS-1:0] rx_data_q,
  output logic rx_valid_q,
  input wire logic rx_ready,
  input wire logic [BYTE_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic bus_error_flag_q,
  input wire logic bus_error_clr
);

  twsb_line_type line_s;
  twsb_line_type line_p_q;
  logic scl_rise;
  logic scl_fall;
  logic scl_high;
  logic sda_rise;
  logic sda_fall;
  logic start_det;
  logic stop_det;
  logic active;
  logic boundary;
  logic addr_match;

  twsb_state_type state_q;
  twsb_state_type state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic need_load_q;
  logic need_load_d;
  logic sda_low_q;
  logic sda_low_d;
  logic scl_hold_q;
  logic scl_hold_d;
  logic [BYTE_BITS-1:0] rx_data_d;
  logic rx_valid_d;
  logic err_d;
  logic pullup_d;

  logic sh_load;
  logic sh_shift;
  logic [BYTE_BITS-1:0] sh_q;

  // pins into the clock domain
  twsb_sync #(
    .W($bits(twsb_line_type)),
    .RST_VAL(LINE_IDLE)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(line_i),
    .q(line_s)
  );

  twsb_shreg u_shreg (
    .clk(clk),
    .rst(rst),
    .load(sh_load),
    .load_val(tx_data),
    .shift(sh_shift),
    .bit_in(line_s.sda),
    .q(sh_q)
  );

  // edges of the synchronised lines
  always_comb
  begin
    scl_rise = line_s.scl & ~line_p_q.scl;
    scl_fall = ~line_s.scl & line_p_q.scl;
    scl_high = line_s.scl & line_p_q.scl;
    sda_rise = line_s.sda & ~line_p_q.sda;
    sda_fall = ~line_s.sda & line_p_q.sda;
    start_det = scl_high & sda_fall;
    stop_det = scl_high & sda_rise;
  end

  // bus state classification
  always_comb
  begin
    active = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
    // first bit still high counts as the byte boundary
    boundary = ((cnt_q == CNT_RST) || (cnt_q == 4'h1))
      && ((state_q == ST_ADDR) || (state_q == ST_RX) || (state_q == ST_TX));
    addr_match = (sh_q[BYTE_BITS-1:1] == own_addr);
  end

  // link next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    nack_d = nack_q;
    need_load_d = need_load_q;
    sda_low_d = sda_low_q;
    rx_data_d = rx_data_q;
    rx_valid_d = rx_valid_q;
    err_d = bus_error_flag_q;
    pullup_d = pullup_cfg;
    sh_load = 1'b0;
    sh_shift = 1'b0;
    tx_ready = 1'b0;
    if (rx_valid_q && rx_ready)
    begin
      rx_valid_d = 1'b0;
    end
    if (bus_error_clr)
    begin
      err_d = 1'b0;
    end
    unique case (state_q)
      ST_IDLE,
      ST_IGNORE:
      begin
        sda_low_d = 1'b0;
        if (start_det)
        begin
          state_d = ST_ADDR;
          cnt_d = CNT_RST;
        end
        else if (stop_det)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_ADDR,
      ST_RX:
      begin
        if (scl_rise)
        begin
          sh_shift = 1'b1;
          cnt_d = cnt_q + 4'h1;
        end
        else if (scl_fall && (cnt_q == CNT_FULL))
        begin
          if (state_q == ST_ADDR)
          begin
            if (addr_match)
            begin
              state_d = ST_ADDR_ACK;
              rw_d = sh_q[RW_POS];
              sda_low_d = 1'b1;
            end
            else
            begin
              state_d = ST_IGNORE;
            end
          end
          else
          begin
            state_d = ST_RX_ACK;
            rx_data_d = sh_q;
            rx_valid_d = 1'b1;
            sda_low_d = 1'b1;
          end
        end
      end
      ST_ADDR_ACK,
      ST_RX_ACK:
      begin
        if (scl_fall)
        begin
          sda_low_d = 1'b0;
          cnt_d = CNT_RST;
          if ((state_q == ST_ADDR_ACK) && rw_q)
          begin
            state_d = ST_TX;
            need_load_d = 1'b1;
          end
          else
          begin
            state_d = ST_RX;
          end
        end
      end
      ST_TX:
      begin
        if (need_load_q)
        begin
          if (tx_valid)
          begin
            tx_ready = 1'b1;
            sh_load = 1'b1;
            need_load_d = 1'b0;
            sda_low_d = ~tx_data[MSB_POS];
          end
        end
        else if (scl_rise)
        begin
          cnt_d = cnt_q + 4'h1;
        end
        else if (scl_fall)
        begin
          if (cnt_q == CNT_FULL)
          begin
            sda_low_d = 1'b0;
            state_d = ST_TX_ACK;
          end
          else
          begin
            sh_shift = 1'b1;
            sda_low_d = ~sh_q[NEXT_MSB_POS];
          end
        end
      end
      ST_TX_ACK:
      begin
        if (scl_rise)
        begin
          nack_d = line_s.sda;
        end
        else if (scl_fall)
        begin
          cnt_d = CNT_RST;
          if (nack_q)
          begin
            state_d = ST_IGNORE;
          end
          else
          begin
            state_d = ST_TX;
            need_load_d = 1'b1;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // start or stop while a transaction runs
    if (active && (start_det || stop_det))
    begin
      cnt_d = CNT_RST;
      need_load_d = 1'b0;
      sda_low_d = 1'b0;
      sh_shift = 1'b0;
      if (boundary && start_det)
      begin
        state_d = ST_ADDR;
      end
      else if (boundary)
      begin
        state_d = ST_IDLE;
      end
      else
      begin
        state_d = ST_IDLE;
        err_d = 1'b1;
      end
    end
  end

  // stretch the low clock at byte start; no low-bound timeout is kept
  always_comb
  begin
    // on a load the data bit leads the clock release by one cycle
    scl_hold_d = ((state_d == ST_TX) && (need_load_d || sh_load))
      || ((state_d == ST_RX) && (cnt_d == CNT_RST) && rx_valid_d);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      need_load_q <= 1'b0;
      sda_low_q <= 1'b0;
      scl_hold_q <= 1'b0;
      rx_data_q <= BYTE_RST;
      rx_valid_q <= 1'b0;
      bus_error_flag_q <= 1'b0;
      pullup_en_q <= PULLUP_RST;
      line_p_q <= LINE_IDLE;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      need_load_q <= need_load_d;
      sda_low_q <= sda_low_d;
      scl_hold_q <= scl_hold_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      bus_error_flag_q <= err_d;
      pullup_en_q <= pullup_d;
      line_p_q <= line_s;
    end
  end

  // open-drain pins: output value always low, enable pulls
  always_comb
  begin
    line_o = LINE_ZERO;
    line_oe.scl = scl_hold_q;
    line_oe.sda = sda_low_q;
  end

endmodule

// >>> sim/twsb_link_asserts.sv
// Purpose: port checker of the slave link
// Assumes: one clock domain, sync reset
// Notes: bound to twsb_link
module twsb_chk
  import twsb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire twsb_line_type line_i,
  input wire twsb_line_type line_o,
  input wire twsb_line_type line_oe,
  input wire logic pullup_cfg,
  input wire logic pullup_en_q,
  input wire logic [BYTE_BITS-1:0] rx_data_q,
  input wire logic rx_valid_q,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic bus_error_flag_q,
  input wire logic bus_error_clr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_OUT_ZERO: assert property (line_o == LINE_ZERO)
    else $error("line output not zero");
  AST_PULLUP: assert property (1'b1 |=> pullup_en_q == $past(pullup_cfg))
    else $error("pull-up enable not following config");
  AST_STRETCH_LOW: assert property ($rose(line_oe.scl) |-> !line_i.scl)
    else $error("clock hold begun while clock high");
  AST_SDA_LOW: assert property ($rose(line_oe.sda) |-> !line_i.scl)
    else $error("data pulled while clock high");
  AST_ERR_STICKY: assert property (bus_error_flag_q && !bus_error_clr |=> bus_error_flag_q)
    else $error("error flag lost");
  AST_ERR_SDA: assert property ($rose(bus_error_flag_q) |-> ##[0:2] !line_oe.sda)
    else $error("data not released on abort");
  AST_RX_HOLD: assert property (rx_valid_q && !rx_ready |=> rx_valid_q && $stable(rx_data_q))
    else $error("received byte not held");
  AST_TX_GO: assert property (tx_ready && tx_valid |=> line_oe.scl ##1 !line_oe.scl)
    else $error("clock not released after byte taken");
  AST_SYNC: assert property ($fell(line_i.scl) |=> $stable(line_oe))
    else $error("outputs moved before sync delay");
endmodule

bind twsb_link twsb_chk twsb_chk_i (.clk(clk), .rst(rst), .line_i(line_i), .line_o(line_o),
  .line_oe(line_oe), .pullup_cfg(pullup_cfg), .pullup_en_q(pullup_en_q),
  .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .bus_error_flag_q(bus_error_flag_q), .bus_error_clr(bus_error_clr));

// >>> sim/twsb_master.sv
// Purpose: bus master model, open drain
// Assumes: wires pulled high when released
// Notes: half clock period 8 cycles
module twsb_master
(
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_lo,
  output logic sda_lo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  task w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task start();
    sda_lo <= 1'b1;
    w(8);
    scl_lo <= 1'b1;
    w(4);
  endtask

  // one bit, clock low at entry and exit
  task bitx(input logic b, output logic r);
    int n;
    n = 0;
    w(4);
    sda_lo <= !b;
    w(4);
    scl_lo <= 1'b0;
    w(1);
    while (!scl && n < 5000)
    begin
      n++;
      w(1);
    end
    w(4);
    r = sda;
    w(3);
    scl_lo <= 1'b1;
  endtask

  task xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(a, k);
  endtask

  task stop();
    w(4);
    sda_lo <= 1'b1;
    w(4);
    scl_lo <= 1'b0;
    w(8);
    sda_lo <= 1'b0;
    w(8);
  endtask
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench of the slave link
// Assumes: master model on the far side
// Notes: wires are wired-and of both parties
module tb
  import twsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADR = 7'h52;
  logic clk = 1'b0;
  logic rst = 1'b1;
  twsb_line_type line_i, line_o, line_oe;
  logic pullup_cfg = 1'b0;
  logic pullup_en_q, rx_valid_q, tx_ready, bus_error_flag_q;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic bus_error_clr = 1'b0;
  logic [7:0] rx_data_q;
  logic [7:0] tx_data = 8'h00;
  logic scl_lo, sda_lo, k;
  logic [7:0] r;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  always #5 clk = !clk;
  assign line_i = {!(scl_lo | line_oe.scl), !(sda_lo | line_oe.sda)};

  twsb_link twsb_link_i (.clk(clk), .rst(rst), .line_i(line_i), .line_o(line_o),
    .line_oe(line_oe), .pullup_cfg(pullup_cfg), .pullup_en_q(pullup_en_q), .own_addr(ADR),
    .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .bus_error_flag_q(bus_error_flag_q),
    .bus_error_clr(bus_error_clr));
  twsb_master twsb_master_i (.clk(clk), .scl(line_i.scl), .sda(line_i.sda),
    .scl_lo(scl_lo), .sda_lo(sda_lo));

  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task results();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      results();
    end
  end

  task t_reset();
    chk("oe", 8'h00, {6'h00, line_oe});
    chk("pullup", 8'h00, {7'h00, pullup_en_q});
    pullup_cfg <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pullup on", 8'h01, {7'h00, pullup_en_q});
  endtask

  task t_write();
    twsb_master_i.start();
    twsb_master_i.xfer({ADR, 1'b0}, 1'b1, r, k);
    chk("addr ack", 8'h00, {7'h00, k});
    twsb_master_i.xfer(8'ha5, 1'b1, r, k);
    chk("data ack", 8'h00, {7'h00, k});
    chk("rx data", 8'ha5, rx_data_q);
    chk("rx valid", 8'h01, {7'h00, rx_valid_q});
    fork
      twsb_master_i.xfer(8'h3c, 1'b1, r, k);
      begin
        repeat (60) @(posedge clk);
        chk("rx stall", 8'h01, {7'h00, line_oe.scl});
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
      end
    join
    chk("rx data 2", 8'h3c, rx_data_q);
    rx_ready <= 1'b1;
    twsb_master_i.stop();
    rx_ready <= 1'b0;
  endtask

  task t_naddr();
    twsb_master_i.start();
    twsb_master_i.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, r, k);
    chk("wrong addr nack", 8'h01, {7'h00, k});
    twsb_master_i.stop();
  endtask

  task t_read();
    tx_data <= 8'h96;
    twsb_master_i.start();
    twsb_master_i.xfer({ADR, 1'b1}, 1'b1, r, k);
    chk("read addr ack", 8'h00, {7'h00, k});
    for (int i = 0; i < 2; i++)
    begin
      fork
        twsb_master_i.xfer(8'hff, i[0], r, k);
        begin
          repeat (60) @(posedge clk);
          chk("tx stall", 8'h01, {7'h00, line_oe.scl});
          tx_valid <= 1'b1;
          #1;
          chk("tx ready", 8'h01, {7'h00, tx_ready});
          @(posedge clk);
          tx_valid <= 1'b0;
          tx_data <= 8'h69;
        end
      join
      chk("read byte", 8'h96 ^ {8{i[0]}}, r);
    end
    twsb_master_i.stop();
  endtask

  task t_err();
    chk("no error", 8'h00, {7'h00, bus_error_flag_q});
    twsb_master_i.start();
    twsb_master_i.xfer({ADR, 1'b0}, 1'b1, r, k);
    for (int i = 0; i < 3; i++)
      twsb_master_i.bitx(i[0], k);
    twsb_master_i.stop();
    chk("bus error", 8'h01, {7'h00, bus_error_flag_q});
    chk("sda released", 8'h00, {7'h00, line_oe.sda});
    bus_error_clr <= 1'b1;
    @(posedge clk);
    bus_error_clr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("error clear", 8'h00, {7'h00, bus_error_flag_q});
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_write();
    t_naddr();
    t_read();
    t_err();
    results();
  end
endmodule
